// File: design/ast_pkg.sv
package ast_pkg;

   // Register select codes on the two select inputs
   localparam logic [1:0] SEL_DATA   = 2'h0;
   localparam logic [1:0] SEL_STATUS = 2'h1;
   localparam logic [1:0] SEL_MODE   = 2'h2;
   localparam logic [1:0] SEL_CMD    = 2'h3;

   // Host-side port addresses of the mode and command registers
   localparam logic [7:0] MODE_IO_ADDR = 8'h42;
   localparam logic [7:0] CMD_IO_ADDR  = 8'h43;

   // First mode register fields
   localparam int M1_FACTOR_LSB = 0;
   localparam int M1_LEN_LSB    = 2;
   localparam int M1_PAR_EN     = 4;
   localparam int M1_PAR_EVEN   = 5;
   localparam int M1_STOP_LSB   = 6;

   // Command register fields
   localparam int CMD_TX_EN    = 0;
   localparam int CMD_DTR      = 1;
   localparam int CMD_RX_EN    = 2;
   localparam int CMD_BREAK    = 3;
   localparam int CMD_ERR_RST  = 4;
   localparam int CMD_RTS      = 5;
   localparam int CMD_LOOP_LSB = 6;

   // Status register fields
   localparam int ST_TX_FREE  = 0;
   localparam int ST_RX_WAIT  = 1;
   localparam int ST_TX_EMPTY = 2;
   localparam int ST_PARITY   = 3;
   localparam int ST_OVERRUN  = 4;
   localparam int ST_FRAMING  = 5;
   localparam int ST_CARRIER  = 6;
   localparam int ST_DSR      = 7;

   // Values after reset
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CMD_RST  = 8'h00;
   localparam logic [7:0] SYN_RST  = 8'h00;

   // Operating loop_select encodings
   localparam logic [1:0] LOOP_NORMAL = 2'h0;
   localparam logic [1:0] LOOP_ECHO   = 2'h1;
   localparam logic [1:0] LOOP_LOCAL  = 2'h2;
   localparam logic [1:0] LOOP_REMOTE = 2'h3;

   // Clock factor, character length and stop bit encodings
   localparam logic [1:0] FACT_X16     = 2'h2;
   localparam logic [1:0] FACT_X64     = 2'h3;
   localparam logic [6:0] DIV_X1       = 7'h01;
   localparam logic [6:0] DIV_X16      = 7'h10;
   localparam logic [6:0] DIV_X64      = 7'h40;
   localparam logic [3:0] CHAR_BASE    = 4'h5;
   localparam logic [1:0] STOP_TWO_MIN = 2'h2;
   localparam int         SYN_COUNT    = 3;

   typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} ast_tx_state_type;
   typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} ast_rx_state_type;

endpackage : ast_pkg

// File: design/ast_transceiver.sv
`timescale 1ns/1ps
module ast_transceiver (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       chip_enable,
   input  wire logic [1:0] register_select,
   input  wire logic       write_in,
   input  wire logic [7:0] parallel_bus_in,
   output logic      [7:0] parallel_bus_out,
   output logic            parallel_bus_oe,
   output logic            tx_holding_free,
   output logic            rx_char_waiting,
   output logic            serial_out,
   input  wire logic       serial_in,
   input  wire logic       tx_bit_clock,
   input  wire logic       rx_bit_clock,
   input  wire logic       carrier_detect_in,
   input  wire logic       clear_to_send_in,
   input  wire logic       data_set_ready_in,
   output logic            data_terminal_ready,
   output logic            request_to_send
);

   function automatic logic [6:0] bit_factor(input logic [1:0] code);
      case (code)
         ast_pkg::FACT_X16: bit_factor = ast_pkg::DIV_X16;
         ast_pkg::FACT_X64: bit_factor = ast_pkg::DIV_X64;
         default:           bit_factor = ast_pkg::DIV_X1;
      endcase
   endfunction : bit_factor

   function automatic logic [3:0] char_bits(input logic [1:0] code);
      char_bits = ast_pkg::CHAR_BASE + {2'h0, code};
   endfunction : char_bits

   ////////////////////////////////////////////////////////////////////////////////
   // Host access decode

   logic                        en_q;
   logic                        mode_ptr_q;
   logic [7:0]                  mode1_q;
   logic [7:0]                  mode2_q;
   logic [7:0]                  cmd_q;
   logic [7:0]                  syn_q [ast_pkg::SYN_COUNT];
   logic [1:0]                  syn_ptr_q;
   logic [7:0]                  rd_data_q;
   logic [7:0]                  rhr_q;
   logic [7:0]                  thr_q;
   logic                        thr_full_q;
   logic                        rx_wait_q;
   logic                        ovr_q;
   logic                        par_err_q;
   logic                        frame_q;
   logic                        access;
   logic                        wr_acc;
   logic                        rd_acc;
   logic                        err_clr;
   logic [7:0]                  status;
   logic [7:0]                  rd_mux;

   // One access per enable pulse; holding enable high does not repeat it
   assign access = chip_enable & ~en_q;
   assign wr_acc = access & write_in;
   assign rd_acc = access & ~write_in;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         en_q <= 1'b0;
      end else begin
         en_q <= chip_enable;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode_ptr_q <= 1'b0;
      end else if (rd_acc && register_select == ast_pkg::SEL_CMD) begin
         mode_ptr_q <= 1'b0;
      end else if (access && register_select == ast_pkg::SEL_MODE) begin
         mode_ptr_q <= ~mode_ptr_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode1_q <= ast_pkg::MODE_RST;
         mode2_q <= ast_pkg::MODE_RST;
      end else if (wr_acc && register_select == ast_pkg::SEL_MODE) begin
         if (mode_ptr_q) begin
            mode2_q <= parallel_bus_in;
         end else begin
            mode1_q <= parallel_bus_in;
         end
      end
   end

   // Error reset is a strobe, never stored
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_q <= ast_pkg::CMD_RST;
      end else if (wr_acc && register_select == ast_pkg::SEL_CMD) begin
         cmd_q <= parallel_bus_in & ~(8'h01 << ast_pkg::CMD_ERR_RST);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         syn_ptr_q <= 2'h0;
         for (int i = 0; i < ast_pkg::SYN_COUNT; i++) begin
            syn_q[i] <= ast_pkg::SYN_RST;
         end
      end else if (rd_acc && register_select == ast_pkg::SEL_CMD) begin
         syn_ptr_q <= 2'h0;
      end else if (wr_acc && register_select == ast_pkg::SEL_STATUS) begin
         syn_q[syn_ptr_q] <= parallel_bus_in;
         syn_ptr_q <= (syn_ptr_q == 2'(ast_pkg::SYN_COUNT - 1)) ? 2'h0 : syn_ptr_q + 2'h1;
      end
   end

   assign err_clr = (wr_acc && register_select == ast_pkg::SEL_CMD
                     && parallel_bus_in[ast_pkg::CMD_ERR_RST])
                    || !cmd_q[ast_pkg::CMD_RX_EN];

   ////////////////////////////////////////////////////////////////////////////////
   // Read path

   logic                        tx_idle;

   always_comb begin
      status                       = 8'h00;
      status[ast_pkg::ST_TX_FREE]  = ~thr_full_q;
      status[ast_pkg::ST_RX_WAIT]  = rx_wait_q;
      status[ast_pkg::ST_TX_EMPTY] = tx_idle & ~thr_full_q;
      status[ast_pkg::ST_PARITY]   = par_err_q;
      status[ast_pkg::ST_OVERRUN]  = ovr_q;
      status[ast_pkg::ST_FRAMING]  = frame_q;
      status[ast_pkg::ST_CARRIER]  = carrier_detect_in;
      status[ast_pkg::ST_DSR]      = data_set_ready_in;
   end

   always_comb begin
      case (register_select)
         ast_pkg::SEL_DATA:   rd_mux = rhr_q;
         ast_pkg::SEL_STATUS: rd_mux = status;
         ast_pkg::SEL_MODE:   rd_mux = mode_ptr_q ? mode2_q : mode1_q;
         default:             rd_mux = cmd_q;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rd_data_q <= 8'h00;
      end else if (rd_acc) begin
         rd_data_q <= rd_mux;
      end
   end

   assign parallel_bus_out = rd_data_q;
   assign parallel_bus_oe  = chip_enable & ~write_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Character format

   logic [6:0]                  factor;
   logic [6:0]                  half;
   logic [3:0]                  nbits;
   logic                        par_en;
   logic                        par_even;
   logic                        two_stop;
   logic [1:0]                  loop_sel;

   assign factor   = bit_factor(mode1_q[ast_pkg::M1_FACTOR_LSB +: 2]);
   assign half     = {1'b0, factor[6:1]};
   assign nbits    = char_bits(mode1_q[ast_pkg::M1_LEN_LSB +: 2]);
   assign par_en   = mode1_q[ast_pkg::M1_PAR_EN];
   assign par_even = mode1_q[ast_pkg::M1_PAR_EVEN];
   assign two_stop = mode1_q[ast_pkg::M1_STOP_LSB +: 2] >= ast_pkg::STOP_TWO_MIN;
   assign loop_sel = cmd_q[ast_pkg::CMD_LOOP_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////////
   // Transmitter

   ast_pkg::ast_tx_state_type   tx_state_q;
   logic                        txc_q;
   logic [6:0]                  tx_cnt_q;
   logic [3:0]                  tx_idx_q;
   logic [7:0]                  tsr_q;
   logic                        tx_par_q;
   logic                        tx_line_q;
   logic                        tx_edge;
   logic                        tx_tick;
   logic                        tx_go;

   assign tx_idle = (tx_state_q == ast_pkg::T_IDLE);
   assign tx_edge = tx_bit_clock & ~txc_q;
   assign tx_tick = tx_edge && (tx_cnt_q == factor - 7'h01);
   // Start is gated, a character already on the line always completes
   assign tx_go   = tx_idle && thr_full_q && cmd_q[ast_pkg::CMD_TX_EN]
                    && clear_to_send_in && (loop_sel != ast_pkg::LOOP_REMOTE);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         thr_q      <= 8'h00;
         thr_full_q <= 1'b0;
      end else begin
         if (wr_acc && register_select == ast_pkg::SEL_DATA) begin
            thr_q      <= parallel_bus_in;
            thr_full_q <= 1'b1;
         end else if (tx_go) begin
            thr_full_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         txc_q    <= 1'b0;
         tx_cnt_q <= 7'h00;
      end else begin
         txc_q <= tx_bit_clock;
         if (tx_idle || tx_tick) begin
            tx_cnt_q <= 7'h00;
         end else if (tx_edge) begin
            tx_cnt_q <= tx_cnt_q + 7'h01;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_state_q <= ast_pkg::T_IDLE;
         tx_idx_q   <= 4'h0;
         tsr_q      <= 8'h00;
         tx_par_q   <= 1'b0;
         tx_line_q  <= 1'b1;
      end else begin
         case (tx_state_q)
            ast_pkg::T_IDLE: begin
               tx_line_q <= 1'b1;
               if (tx_go) begin
                  tsr_q      <= thr_q;
                  tx_idx_q   <= 4'h0;
                  tx_par_q   <= ~par_even;
                  tx_line_q  <= 1'b0;
                  tx_state_q <= ast_pkg::T_START;
               end
            end
            ast_pkg::T_START: begin
               if (tx_tick) begin
                  tx_line_q  <= tsr_q[0];
                  tx_state_q <= ast_pkg::T_DATA;
               end
            end
            ast_pkg::T_DATA: begin
               if (tx_tick) begin
                  tx_par_q <= tx_par_q ^ tsr_q[0];
                  tsr_q    <= {1'b0, tsr_q[7:1]};
                  tx_idx_q <= tx_idx_q + 4'h1;
                  if (tx_idx_q == nbits - 4'h1) begin
                     tx_idx_q <= 4'h0;
                     if (par_en) begin
                        tx_line_q  <= tx_par_q ^ tsr_q[0];
                        tx_state_q <= ast_pkg::T_PAR;
                     end else begin
                        tx_line_q  <= 1'b1;
                        tx_state_q <= ast_pkg::T_STOP;
                     end
                  end else begin
                     tx_line_q <= tsr_q[1];
                  end
               end
            end
            ast_pkg::T_PAR: begin
               if (tx_tick) begin
                  tx_line_q  <= 1'b1;
                  tx_state_q <= ast_pkg::T_STOP;
               end
            end
            ast_pkg::T_STOP: begin
               if (tx_tick) begin
                  if (two_stop && tx_idx_q == 4'h0) begin
                     tx_idx_q <= 4'h1;
                  end else begin
                     tx_state_q <= ast_pkg::T_IDLE;
                  end
               end
            end
            default: tx_state_q <= ast_pkg::T_IDLE;
         endcase
      end
   end

   // Output registered so loop switching never glitches the line
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         serial_out <= 1'b1;
      end else if (cmd_q[ast_pkg::CMD_BREAK]) begin
         serial_out <= 1'b0;
      end else if (loop_sel == ast_pkg::LOOP_ECHO || loop_sel == ast_pkg::LOOP_REMOTE) begin
         serial_out <= serial_in;
      end else if (loop_sel == ast_pkg::LOOP_LOCAL) begin
         serial_out <= 1'b1;
      end else begin
         serial_out <= tx_line_q;
      end
   end

   assign tx_holding_free     = ~thr_full_q;
   assign data_terminal_ready = cmd_q[ast_pkg::CMD_DTR];
   assign request_to_send     = cmd_q[ast_pkg::CMD_RTS] | ~tx_idle;

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver

   ast_pkg::ast_rx_state_type   rx_state_q;
   logic                        rxc_q;
   logic [6:0]                  rx_cnt_q;
   logic [3:0]                  rx_idx_q;
   logic [7:0]                  rsr_q;
   logic                        rx_acc_q;
   logic                        rx_line;
   logic                        rx_on;
   logic                        rx_edge;
   logic                        rx_sample;
   logic                        rx_load;
   logic                        rd_data;

   assign rx_line   = (loop_sel == ast_pkg::LOOP_LOCAL) ? tx_line_q : serial_in;
   assign rx_on     = carrier_detect_in && cmd_q[ast_pkg::CMD_RX_EN]
                      && (loop_sel != ast_pkg::LOOP_REMOTE);
   assign rx_edge   = rx_bit_clock & ~rxc_q;
   assign rx_sample = rx_edge && (rx_cnt_q == factor - 7'h01);
   assign rx_load   = rx_on && (rx_state_q == ast_pkg::R_STOP) && rx_sample;
   assign rd_data   = rd_acc && (register_select == ast_pkg::SEL_DATA);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rxc_q <= 1'b0;
      end else begin
         rxc_q <= rx_bit_clock;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !rx_on) begin
         rx_state_q <= ast_pkg::R_IDLE;
         rx_cnt_q   <= 7'h00;
         rx_idx_q   <= 4'h0;
         rsr_q      <= 8'h00;
         rx_acc_q   <= 1'b0;
      end else if (rx_edge) begin
         rx_cnt_q <= rx_cnt_q + 7'h01;
         case (rx_state_q)
            ast_pkg::R_IDLE: begin
               rx_cnt_q <= 7'h00;
               if (!rx_line) begin
                  rx_idx_q   <= 4'h0;
                  rsr_q      <= 8'h00;
                  rx_acc_q   <= ~par_even;
                  // At factor one the detecting edge is already mid-bit
                  rx_state_q <= (factor == ast_pkg::DIV_X1) ? ast_pkg::R_DATA
                                                             : ast_pkg::R_START;
               end
            end
            ast_pkg::R_START: begin
               if (rx_cnt_q == half - 7'h01) begin
                  rx_cnt_q   <= 7'h00;
                  rx_state_q <= rx_line ? ast_pkg::R_IDLE : ast_pkg::R_DATA;
               end
            end
            ast_pkg::R_DATA: begin
               if (rx_sample) begin
                  rx_cnt_q            <= 7'h00;
                  rsr_q[rx_idx_q[2:0]] <= rx_line;
                  rx_acc_q            <= rx_acc_q ^ rx_line;
                  rx_idx_q            <= rx_idx_q + 4'h1;
                  if (rx_idx_q == nbits - 4'h1) begin
                     rx_state_q <= par_en ? ast_pkg::R_PAR : ast_pkg::R_STOP;
                  end
               end
            end
            ast_pkg::R_PAR: begin
               if (rx_sample) begin
                  rx_cnt_q   <= 7'h00;
                  rx_acc_q   <= rx_acc_q ^ rx_line;
                  rx_state_q <= ast_pkg::R_STOP;
               end
            end
            ast_pkg::R_STOP: begin
               if (rx_sample) begin
                  rx_cnt_q   <= 7'h00;
                  rx_state_q <= ast_pkg::R_IDLE;
               end
            end
            default: rx_state_q <= ast_pkg::R_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rhr_q <= 8'h00;
      end else if (rx_load) begin
         rhr_q <= rsr_q;
      end
   end

   // New character wins over a read in the same cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rx_wait_q <= 1'b0;
      end else begin
         rx_wait_q <= rx_load | (rx_wait_q & ~rd_data);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ovr_q     <= 1'b0;
         par_err_q <= 1'b0;
         frame_q   <= 1'b0;
      end else begin
         ovr_q     <= (rx_load & rx_wait_q & ~rd_data) | (ovr_q & ~err_clr);
         par_err_q <= (rx_load & par_en & rx_acc_q) | (par_err_q & ~err_clr);
         frame_q   <= (rx_load & ~rx_line) | (frame_q & ~err_clr);
      end
   end

   assign rx_char_waiting = rx_wait_q;

endmodule : ast_transceiver

// File: test/ast_host_model.sv
`timescale 1ns/1ps
module ast_host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] bus_wire,
   output logic            chip_enable,
   output logic [1:0]      register_select,
   output logic            write_in,
   output logic [7:0]      bus_drive
);
   initial begin
      chip_enable = 1'b0;
      register_select = 2'h0;
      write_in = 1'b0;
      bus_drive = 8'h00;
   end
   // Enable held over the answer edge; read data is taken while still driven
   task automatic acc(input logic wr, input logic [1:0] sel, input logic [7:0] wd,
                      output logic [7:0] rd);
      @(posedge ref_clk);
      chip_enable <= 1'b1;
      register_select <= sel;
      write_in <= wr;
      bus_drive <= wd;
      repeat (2) @(posedge ref_clk);
      rd = bus_wire;
      chip_enable <= 1'b0;
      // Released lines flip so stale data cannot pass
      bus_drive <= ~wd;
   endtask : acc
endmodule : ast_host_model

// File: test/ast_transceiver_props.sv
`timescale 1ns/1ps
module ast_transceiver_props (
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   input wire logic       chip_enable,
   input wire logic [1:0] register_select,
   input wire logic       write_in,
   input wire logic [7:0] parallel_bus_in,
   input wire logic       parallel_bus_oe,
   input wire logic       tx_holding_free,
   input wire logic       rx_char_waiting,
   input wire logic       serial_out,
   input wire logic       serial_in,
   input wire logic       data_terminal_ready,
   input wire logic       request_to_send
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic       en_q;
   logic [7:0] cmd_q;
   logic       take;
   logic       brk;
   logic [1:0] loop;
   assign take = chip_enable & ~en_q;
   assign brk  = cmd_q[ast_pkg::CMD_BREAK];
   assign loop = cmd_q[7:6];
   // Shadow of the command register, built from bus traffic only
   always_ff @(posedge ref_clk) begin
      en_q <= chip_enable;
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_q <= ast_pkg::CMD_RST;
      end else if (take && write_in && register_select == ast_pkg::SEL_CMD) begin
         cmd_q <= parallel_bus_in;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_bus_oe;
      parallel_bus_oe == (chip_enable & ~write_in);
   endproperty
   a_bus_oe: assert property (p_bus_oe) else $error("bus enable wrong");
   property p_reset;
      disable iff (1'b0) sys_rst |=> tx_holding_free && !rx_char_waiting && serial_out
         && !data_terminal_ready && !request_to_send;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_tx_load;
      take && write_in && register_select == ast_pkg::SEL_DATA |=> !tx_holding_free;
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("tx free stayed");
   property p_rx_read;
      take && !write_in && register_select == ast_pkg::SEL_DATA |=> !rx_char_waiting;
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("rx waiting stayed");
   property p_dtr;
      take && write_in && register_select == ast_pkg::SEL_CMD
         |=> ##[0:1] data_terminal_ready == cmd_q[ast_pkg::CMD_DTR];
   endproperty
   a_dtr: assert property (p_dtr) else $error("dtr mismatch");
   property p_break;
      brk [*3] |-> !serial_out;
   endproperty
   a_break: assert property (p_break) else $error("break not held");
   property p_local;
      (loop == ast_pkg::LOOP_LOCAL && !brk) [*3] |-> serial_out;
   endproperty
   a_local: assert property (p_local) else $error("local loop line low");
   property p_echo;
      (loop[0] && !brk && $stable(serial_in)) [*4] |-> serial_out == serial_in;
   endproperty
   a_echo: assert property (p_echo) else $error("echo mismatch");
   property p_rts;
      (loop == ast_pkg::LOOP_NORMAL && !brk && !serial_out) [*3] |-> request_to_send;
   endproperty
   a_rts: assert property (p_rts) else $error("rts low while sending");
endmodule : ast_transceiver_props
bind ast_transceiver ast_transceiver_props props_u (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .chip_enable(chip_enable),
   .register_select(register_select), .write_in(write_in),
   .parallel_bus_in(parallel_bus_in), .parallel_bus_oe(parallel_bus_oe),
   .tx_holding_free(tx_holding_free), .rx_char_waiting(rx_char_waiting),
   .serial_out(serial_out), .serial_in(serial_in),
   .data_terminal_ready(data_terminal_ready), .request_to_send(request_to_send));

// File: test/async_serial_transceiver_tb.sv
`timescale 1ns/1ps
module async_serial_transceiver_tb;
   logic ref_clk, sys_rst, serial_in, rx_bit_clock, tx_bit_clock, tx_run;
   logic carrier_detect_in, clear_to_send_in, data_set_ready_in;
   logic [2:0] tcnt;
   wire logic ce, wr, oe, free, waiting, sout, dtr, rts;
   wire logic [1:0] sel;
   wire logic [7:0] drive, dout, bus_wire;
   int miscompares, checks, seed;
   logic [7:0] rd, b;
   logic m_full, m_ovr, m_fr, m_par, pe, rx_on;
   logic [7:0] exp_q[$];
   assign bus_wire = oe ? dout : drive;
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Bit clock stands still outside transmit frames
   always @(posedge ref_clk) begin
      tcnt <= tx_run ? tcnt + 3'h1 : 3'h0;
      tx_bit_clock <= tx_run & tcnt[2];
   end
   ast_transceiver dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_enable(ce),
      .register_select(sel), .write_in(wr), .parallel_bus_in(bus_wire),
      .parallel_bus_out(dout), .parallel_bus_oe(oe), .tx_holding_free(free),
      .rx_char_waiting(waiting), .serial_out(sout), .serial_in(serial_in),
      .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
      .carrier_detect_in(carrier_detect_in), .clear_to_send_in(clear_to_send_in),
      .data_set_ready_in(data_set_ready_in), .data_terminal_ready(dtr),
      .request_to_send(rts));
   ast_host_model host_u (.ref_clk(ref_clk), .bus_wire(bus_wire), .chip_enable(ce),
      .register_select(sel), .write_in(wr), .bus_drive(drive));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (miscompares == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp8
   task automatic rdreg(input logic [1:0] s, input logic [7:0] e, input logic [7:0] m,
                        input string what);
      host_u.acc(1'b0, s, 8'h00, rd);
      cmp8(what, e, rd & m);
   endtask : rdreg
   task automatic wrreg(input logic [1:0] s, input logic [7:0] v);
      host_u.acc(1'b1, s, v, rd);
   endtask : wrreg
   task automatic rd_stat;
      rdreg(ast_pkg::SEL_STATUS, {data_set_ready_in, carrier_detect_in, m_fr, m_ovr, m_par,
            1'b0, m_full, 1'b0}, 8'hFA, "status");
   endtask : rd_stat
   task automatic rd_data;
      rdreg(ast_pkg::SEL_DATA, exp_q.pop_front(), 8'hFF, "rx data");
      m_full = 1'b0;
   endtask : rd_data
   // Far-end sender; model keeps only the newest unread character
   task automatic rx(input logic stop, input logic bad);
      logic [10:0] f;
      b = $random(seed);
      f = pe ? {stop, ~^b ^ bad, b, 1'b0} : {1'b1, stop, b, 1'b0};
      for (int i = 0; i < (pe ? 11 : 10); i++) begin
         serial_in <= f[i];
         repeat (pe ? 16 : 1) begin
            repeat (4) @(posedge ref_clk);
            rx_bit_clock <= 1'b1;
            repeat (4) @(posedge ref_clk);
            rx_bit_clock <= 1'b0;
         end
      end
      serial_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      if (rx_on && carrier_detect_in) begin
         if (m_full) exp_q.pop_front();
         m_ovr |= m_full;
         m_full = 1'b1;
         m_fr |= !stop;
         m_par |= pe & bad;
         exp_q.push_back(b);
      end
   endtask : rx
   task automatic tx_check(input logic [7:0] d);
      int k;
      logic [9:0] bits;
      k = 0;
      while (sout !== 1'b0 && k < 200) begin
         @(posedge ref_clk);
         k++;
      end
      if (k == 200) begin
         miscompares++;
         close_out();
      end
      tx_run <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(posedge tx_bit_clock);
         repeat (4) @(posedge ref_clk);
         bits[i] = sout;
      end
      tx_run <= 1'b0;
      cmp8("tx data", d, bits[7:0]);
      cmp8("tx stop", 8'h01, {7'h00, bits[8]});
   endtask : tx_check
   initial begin
      repeat (100000) @(posedge ref_clk);
      miscompares++;
      close_out();
   end
   initial begin
      seed = 32'hD7B6;
      {miscompares, checks} = 0;
      {tx_run, rx_bit_clock, clear_to_send_in} = 0;
      {m_full, m_ovr, m_fr, m_par, pe} = 0;
      {serial_in, carrier_detect_in, data_set_ready_in, rx_on, sys_rst} = 5'h1F;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_stat();
      rdreg(ast_pkg::SEL_MODE, 8'h00, 8'hFF, "mode1");
      rdreg(ast_pkg::SEL_MODE, 8'h00, 8'hFF, "mode2");
      rdreg(ast_pkg::SEL_CMD, 8'h00, 8'hFF, "cmd");
      wrreg(ast_pkg::SEL_MODE, 8'h0C);
      wrreg(ast_pkg::SEL_MODE, 8'hA5);
      rdreg(ast_pkg::SEL_MODE, 8'h0C, 8'hFF, "mode1");
      rdreg(ast_pkg::SEL_MODE, 8'hA5, 8'hFF, "mode2");
      rdreg(ast_pkg::SEL_CMD, 8'h00, 8'hFF, "cmd");
      rdreg(ast_pkg::SEL_MODE, 8'h0C, 8'hFF, "mode1");
      wrreg(ast_pkg::SEL_CMD, 8'h07);
      rdreg(ast_pkg::SEL_CMD, 8'h07, 8'hFF, "cmd");
      cmp8("rts", 8'h00, {7'h00, rts});
      b = $random(seed);
      wrreg(ast_pkg::SEL_DATA, b);
      cmp8("tx free", 8'h00, {7'h00, free});
      repeat (40) @(posedge ref_clk);
      cmp8("line idle", 8'h01, {7'h00, sout});
      clear_to_send_in <= 1'b1;
      tx_check(b);
      cmp8("tx free", 8'h01, {7'h00, free});
      wrreg(ast_pkg::SEL_STATUS, $random(seed));
      rx(1'b1, 1'b0);
      cmp8("rx waiting", 8'h01, {7'h00, waiting});
      rd_stat();
      rd_data();
      cmp8("rx waiting", 8'h00, {7'h00, waiting});
      rx(1'b1, 1'b0);
      rx(1'b1, 1'b0);
      rd_stat();
      rd_data();
      rx(1'b0, 1'b0);
      rd_stat();
      rd_data();
      wrreg(ast_pkg::SEL_CMD, 8'h37);
      {m_ovr, m_fr} = 0;
      rd_stat();
      rdreg(ast_pkg::SEL_CMD, 8'h27, 8'hFF, "cmd");
      wrreg(ast_pkg::SEL_MODE, 8'h1E);
      pe = 1'b1;
      rx(1'b1, 1'b1);
      rd_stat();
      wrreg(ast_pkg::SEL_CMD, 8'h23);
      {m_par, rx_on} = 0;
      rx(1'b1, 1'b0);
      rd_stat();
      rd_data();
      wrreg(ast_pkg::SEL_CMD, 8'h27);
      {carrier_detect_in, data_set_ready_in, rx_on} <= 3'h1;
      rx(1'b1, 1'b0);
      rd_stat();
      for (int m = 0; m < 4; m++) begin
         wrreg(ast_pkg::SEL_CMD, {m[1:0], 6'h27});
         for (int v = 0; v < 2; v++) begin
            serial_in <= v[0];
            repeat (6) @(posedge ref_clk);
            cmp8("loop line", {7'h00, m[0] ? v[0] : 1'b1}, {7'h00, sout});
         end
      end
      wrreg(ast_pkg::SEL_CMD, 8'h2F);
      repeat (4) @(posedge ref_clk);
      cmp8("break", 8'h00, {7'h00, sout});
      close_out();
   end
endmodule : async_serial_transceiver_tb
